// file: rtl/pml_params.svh
// Offsets, field positions, reset values and address constants of the
// per-port copper management register bank. Included by the package and core.
// Contract
// - Near loopback returns a port's line receive symbols out its own transmit pair.
// - Switch register 26 bit 1 / 42 bit 1 enable near loopback per port.
// - Management register 31 bit 1 is an alternative near loopback control.
// - After reset the PHYs answer management addresses 0x1 and 0x2.
// - Switch register 15 bits 7..3 relocate the PHY management addresses.
// - Only register addresses 0x0-0x5, 0x1D and 0x1F are implemented.
// - Register 0x1D exists on port 2 only; unsupported on port 1.
// - Switch-side port reaches the same bits through its own byte map.
// - Control bit 14 starts far loopback through the other port; tracks 29/45 bit 0.
// - Control bit 13 forces 100 Mbps, resets 0, tracks 28/44 bit 6.
// - Control bit 12 enables autonegotiation, resets 1, tracks 28/44 bit 7.
// - Control bit 11 powers down, resets 0, tracks 29/45 bit 3.
// - Writing 1 to control bit 9 restarts autonegotiation; tracks 29/45 bit 5.
// - Control bit 8 forces full duplex, resets 0, tracks 28/44 bit 5.
// - Control bit 5 picks crossover algorithm, resets 1, tracks 31/47 bit 7.
// - Control bit 4 forces straight mode, resets 0, tracks 29/45 bit 1.
// - Control bit 3 disables crossover detection, resets 0, tracks 29/45 bit 2.
// - Control bit 2 disables far-end fault detection, tracks 29/45 bit 4.
// - Control bit 1 disables the transmitter, tracks 29/45 bit 6.
// - Control bit 0 disables indicator outputs, tracks 29/45 bit 7.
`ifndef PML_PARAMS_SVH
`define PML_PARAMS_SVH
`define PML_SYM_W 5
`define PML_RA_CTL 5'h00
`define PML_RA_LAST_STD 5'h05
`define PML_RA_DIAG 5'h1d
`define PML_RA_SPECIAL 5'h1f
`define PML_SPECIAL_NLOOP 1
`define PML_SW_GLOBAL13 8'h0f
`define PML_SW_NLOOP 8'h1a
`define PML_SW_CTL_A 8'h1c
`define PML_SW_CTL_B 8'h1d
`define PML_SW_XOVER 8'h1f
`define PML_SW_STRIDE 8'h10
`define PML_PHY_BASE_RST 5'h01
`define PML_CTL_RST 16'h1020
`endif

// file: rtl/pml_pkg.sv
// Types shared by the management register bank and its users.
// Assumes pml_params.svh is on the include path.
`include "pml_params.svh"
package pml_pkg;
	// Per-port control bits as seen by the PHY logic
	typedef struct packed {
		logic far_loop;
		logic force100;
		logic autoneg_enable;
		logic pdown;
		logic autoneg_restart;
		logic fdx;
		logic crossover_algorithm_select;
		logic force_straight_mode;
		logic crossover_detect_disable;
		logic ffault_dis;
		logic tx_dis;
		logic indicator_disable;
		logic near_loop;
	} pml_port_ctl_t;
	// One decoded management transaction
	typedef struct packed {
		logic req;
		logic write;
		logic [4:0] phy_select_address;
		logic [4:0] register_select_address;
		logic [15:0] wdata;
	} pml_mgmt_req_t;
	// One switch-map byte access
	typedef struct packed {
		logic req;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pml_sw_req_t;
	typedef struct packed {
		pml_port_ctl_t [1:0] port;
		logic [4:0] phy_base;
		logic ack;
		logic unsup;
		logic [15:0] rdata;
		logic [7:0] sw_rdata;
		logic [1:0][`PML_SYM_W-1:0] tx;
	} pml_state_t;
endpackage

// file: rtl/pml_core.sv
// Management register bank for the two copper ports, with loopback muxing.
// Assumes decoded management transactions and a synchronous 100 MHz clock.
`timescale 1ns/1ns
`include "pml_params.svh"
module pml_core (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire pml_pkg::pml_mgmt_req_t i_mgmt,
	output logic o_mgmt_ack,
	output logic o_mgmt_unsup,
	output logic [15:0] o_mgmt_rdata,
	input wire pml_pkg::pml_sw_req_t i_sw,
	output logic [7:0] o_sw_rdata,
	input wire logic [1:0][`PML_SYM_W-1:0] i_line_rx,
	input wire logic [1:0][`PML_SYM_W-1:0] i_mac_tx,
	output logic [1:0][`PML_SYM_W-1:0] o_line_tx,
	output pml_pkg::pml_port_ctl_t [1:0] o_port_ctl
);
	pml_pkg::pml_state_t st;
	pml_pkg::pml_state_t next_st;

	////////////////////////////////////////////////////////////////////////
	// Field packing helpers

	// Control word view; unsupported bits stay zero
	function automatic logic [15:0] ctl_word(input pml_pkg::pml_port_ctl_t c);
		logic [15:0] w;
		w = 16'h0000;
		w[14] = c.far_loop;
		w[13] = c.force100;
		w[12] = c.autoneg_enable;
		w[11] = c.pdown;
		w[9] = c.autoneg_restart;
		w[8] = c.fdx;
		w[5] = c.crossover_algorithm_select;
		w[4] = c.force_straight_mode;
		w[3] = c.crossover_detect_disable;
		w[2] = c.ffault_dis;
		w[1] = c.tx_dis;
		w[0] = c.indicator_disable;
		return w;
	endfunction

	// Load writable control bits from a word
	function automatic pml_pkg::pml_port_ctl_t ctl_load(input pml_pkg::pml_port_ctl_t c,
			input logic [15:0] w);
		pml_pkg::pml_port_ctl_t r;
		r = c;
		r.far_loop = w[14];
		r.force100 = w[13];
		r.autoneg_enable = w[12];
		r.pdown = w[11];
		r.autoneg_restart = w[9];
		r.fdx = w[8];
		r.crossover_algorithm_select = w[5];
		r.force_straight_mode = w[4];
		r.crossover_detect_disable = w[3];
		r.ffault_dis = w[2];
		r.tx_dis = w[1];
		r.indicator_disable = w[0];
		return r;
	endfunction

	// Switch-map address of a port register
	function automatic logic [7:0] sw_addr(input logic [7:0] a, input logic p);
		return p ? a + `PML_SW_STRIDE : a;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	// Decode both access paths and compute loopback muxing
	always_comb begin
		logic [4:0] pa;
		logic [15:0] rd;
		logic [7:0] sb;
		logic hit;
		logic sup;
		pa = 5'h00;
		rd = 16'h0000;
		sb = 8'h00;
		hit = 1'b0;
		sup = 1'b0;
		next_st = st;
		next_st.ack = 1'b0;
		next_st.unsup = 1'b0;
		next_st.rdata = 16'h0000;
		next_st.sw_rdata = 8'h00;
		// Restart request lasts one cycle
		for (int p = 0; p < 2; p++) begin
			next_st.port[p].autoneg_restart = 1'b0;
		end
		// Switch-map reads and writes of the shared bits
		if (i_sw.req) begin
			if (i_sw.addr == `PML_SW_GLOBAL13) begin
				sb[7:3] = st.phy_base;
				if (i_sw.write) begin
					next_st.phy_base = i_sw.wdata[7:3];
				end
			end
			for (int p = 0; p < 2; p++) begin
				if (i_sw.addr == sw_addr(`PML_SW_NLOOP, 1'(p))) begin
					sb[1] = st.port[p].near_loop;
					if (i_sw.write) begin
						next_st.port[p].near_loop = i_sw.wdata[1];
					end
				end
				if (i_sw.addr == sw_addr(`PML_SW_CTL_A, 1'(p))) begin
					sb = {st.port[p].autoneg_enable, st.port[p].force100,
						st.port[p].fdx, 5'h00};
					if (i_sw.write) begin
						next_st.port[p].autoneg_enable = i_sw.wdata[7];
						next_st.port[p].force100 = i_sw.wdata[6];
						next_st.port[p].fdx = i_sw.wdata[5];
					end
				end
				if (i_sw.addr == sw_addr(`PML_SW_CTL_B, 1'(p))) begin
					sb = {st.port[p].indicator_disable, st.port[p].tx_dis,
						st.port[p].autoneg_restart, st.port[p].ffault_dis,
						st.port[p].pdown, st.port[p].crossover_detect_disable,
						st.port[p].force_straight_mode, st.port[p].far_loop};
					if (i_sw.write) begin
						next_st.port[p].indicator_disable = i_sw.wdata[7];
						next_st.port[p].tx_dis = i_sw.wdata[6];
						next_st.port[p].autoneg_restart = i_sw.wdata[5];
						next_st.port[p].ffault_dis = i_sw.wdata[4];
						next_st.port[p].pdown = i_sw.wdata[3];
						next_st.port[p].crossover_detect_disable = i_sw.wdata[2];
						next_st.port[p].force_straight_mode = i_sw.wdata[1];
						next_st.port[p].far_loop = i_sw.wdata[0];
					end
				end
				if (i_sw.addr == sw_addr(`PML_SW_XOVER, 1'(p))) begin
					sb[7] = st.port[p].crossover_algorithm_select;
					if (i_sw.write) begin
						next_st.port[p].crossover_algorithm_select = i_sw.wdata[7];
					end
				end
			end
			next_st.sw_rdata = sb;
		end
		// Management path; wins over the switch map in a shared cycle
		if (i_mgmt.req) begin
			for (int p = 0; p < 2; p++) begin
				pa = st.phy_base + 5'(p);
				if (i_mgmt.phy_select_address == pa) begin
					hit = 1'b1;
					case (i_mgmt.register_select_address)
						`PML_RA_CTL: begin
							sup = 1'b1;
							rd = ctl_word(st.port[p]);
							if (i_mgmt.write) begin
								next_st.port[p] = ctl_load(next_st.port[p], i_mgmt.wdata);
							end
						end
						`PML_RA_SPECIAL: begin
							sup = 1'b1;
							rd[`PML_SPECIAL_NLOOP] = st.port[p].near_loop;
							if (i_mgmt.write) begin
								next_st.port[p].near_loop = i_mgmt.wdata[`PML_SPECIAL_NLOOP];
							end
						end
						`PML_RA_DIAG: begin
							sup = (p == 1);
						end
						default: begin
							sup = (i_mgmt.register_select_address <= `PML_RA_LAST_STD);
						end
					endcase
				end
			end
			next_st.ack = hit;
			next_st.unsup = hit & ~sup;
			next_st.rdata = sup ? rd : 16'h0000;
		end
		// Line transmit selection per port
		for (int p = 0; p < 2; p++) begin
			if (st.port[p].tx_dis | st.port[p].pdown) begin
				next_st.tx[p] = '0;
			end else if (st.port[p].near_loop | st.port[1 - p].far_loop) begin
				next_st.tx[p] = i_line_rx[p];
			end else begin
				next_st.tx[p] = i_mac_tx[p];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	// Synchronous reset to documented defaults
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			st <= '0;
			st.phy_base <= `PML_PHY_BASE_RST;
			for (int p = 0; p < 2; p++) begin
				st.port[p] <= ctl_load('0, `PML_CTL_RST);
			end
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state
	assign o_mgmt_ack = st.ack;
	assign o_mgmt_unsup = st.unsup;
	assign o_mgmt_rdata = st.rdata;
	assign o_sw_rdata = st.sw_rdata;
	assign o_line_tx = st.tx;
	assign o_port_ctl = st.port;

	////////////////////////////////////////////////////////////////////////
	// Checks

	property p_near_loop;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(st.port[0].near_loop && !st.port[0].tx_dis && !st.port[0].pdown) |=>
			(o_line_tx[0] == $past(i_line_rx[0]));
	endproperty
	a_near_loop: assert property (p_near_loop) else $error("near loop data lost");

	property p_sw_nloop;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(i_sw.req && i_sw.write && i_sw.addr == 8'h2a && !i_mgmt.req) |=>
			(o_port_ctl[1].near_loop == $past(i_sw.wdata[1]));
	endproperty
	a_sw_nloop: assert property (p_sw_nloop) else $error("reg 42 loop bit not taken");

	property p_reset_addr;
		@(posedge i_mclk) $rose(i_rst_b) |-> (st.phy_base == 5'h01);
	endproperty
	a_reset_addr: assert property (p_reset_addr) else $error("phy base not 1 after reset");

	property p_ack_addr;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(i_mgmt.req && i_mgmt.phy_select_address == st.phy_base) |=> o_mgmt_ack;
	endproperty
	a_ack_addr: assert property (p_ack_addr) else $error("own address not answered");

	property p_unsup;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(i_mgmt.req && i_mgmt.phy_select_address == st.phy_base
			&& i_mgmt.register_select_address == 5'h0a) |=> (o_mgmt_unsup && o_mgmt_rdata == 16'h0000);
	endproperty
	a_unsup: assert property (p_unsup) else $error("unsupported address accepted");

	property p_diag_p1;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(i_mgmt.req && i_mgmt.phy_select_address == st.phy_base
			&& i_mgmt.register_select_address == 5'h1d) |=> o_mgmt_unsup;
	endproperty
	a_diag_p1: assert property (p_diag_p1) else $error("port 1 diag register answered");

	property p_restart;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(o_port_ctl[0].autoneg_restart && !i_mgmt.req && !i_sw.req)
			|=> !o_port_ctl[0].autoneg_restart;
	endproperty
	a_restart: assert property (p_restart) else $error("restart held over");

	property p_ro_bits;
		@(posedge i_mclk) disable iff (!i_rst_b)
		o_mgmt_ack |-> ((o_mgmt_rdata & 16'h84c0) == 16'h0000);
	endproperty
	a_ro_bits: assert property (p_ro_bits) else $error("read-only bits not zero");

	property p_far_loop;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(st.port[0].far_loop && !st.port[1].near_loop && !st.port[1].tx_dis && !st.port[1].pdown)
			|=> (o_line_tx[1] == $past(i_line_rx[1]));
	endproperty
	a_far_loop: assert property (p_far_loop) else $error("far loop path wrong");

	property p_tx_dis;
		@(posedge i_mclk) disable iff (!i_rst_b)
		o_port_ctl[1].tx_dis |=> (o_line_tx[1] == '0);
	endproperty
	a_tx_dis: assert property (p_tx_dis) else $error("transmit not disabled");

	property p_nloop_mgmt;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(i_mgmt.req && i_mgmt.write && i_mgmt.phy_select_address == st.phy_base + 5'h01
			&& i_mgmt.register_select_address == 5'h1f)
			|=> (o_port_ctl[1].near_loop == $past(i_mgmt.wdata[1]));
	endproperty
	a_nloop_mgmt: assert property (p_nloop_mgmt) else $error("special loop bit not taken");

	property p_ctl_force;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(i_mgmt.req && i_mgmt.write && i_mgmt.phy_select_address == st.phy_base + 5'h01
			&& i_mgmt.register_select_address == 5'h00)
			|=> (o_port_ctl[1].force100 == $past(i_mgmt.wdata[13]));
	endproperty
	a_ctl_force: assert property (p_ctl_force) else $error("speed bit not taken");

	property p_no_ack;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(i_mgmt.req && i_mgmt.phy_select_address != st.phy_base
			&& i_mgmt.phy_select_address != st.phy_base + 5'h01) |=> !o_mgmt_ack;
	endproperty
	a_no_ack: assert property (p_no_ack) else $error("foreign address answered");

	property p_mac_path;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(!st.port[0].near_loop && !st.port[1].far_loop && !st.port[0].tx_dis && !st.port[0].pdown)
			|=> (o_line_tx[0] == $past(i_mac_tx[0]));
	endproperty
	a_mac_path: assert property (p_mac_path) else $error("normal transmit path wrong");

	property p_pdown;
		@(posedge i_mclk) disable iff (!i_rst_b)
		o_port_ctl[0].pdown |=> (o_line_tx[0] == '0);
	endproperty
	a_pdown: assert property (p_pdown) else $error("powered-down port transmits");

endmodule

// file: bench/pml_mgmt_master.sv
// Station management master model for the copper register bank.
// Assumes the core takes one decoded request per rising edge of i_mclk.
`timescale 1ns/1ns
module pml_mgmt_master (
	input wire logic i_mclk,
	output pml_pkg::pml_mgmt_req_t o_mgmt
);
	////////////////////////////////////////////////////////////////////////////////
	// Idle at time zero
	initial o_mgmt = '0;

	// One access held for a single cycle, launched off the falling edge
	task automatic access(input logic wr, input logic [4:0] phy, input logic [4:0] ra,
		input logic [15:0] wd);
		@(negedge i_mclk);
		o_mgmt = '{1'b1, wr, phy, ra, wd};
		@(negedge i_mclk);
		o_mgmt = '{1'b0, 1'b0, ~phy, ~ra, ~wd}; // Stale fields flipped
	endtask
endmodule

// file: bench/phy_mii_control_loopback_tb_top.sv
// Self-checking bench for the copper management register bank.
// Assumes the package, core and management master model are compiled first.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module phy_mii_control_loopback_tb_top;
	logic i_mclk = 1'b0;
	logic i_rst_b = 1'b0;
	pml_pkg::pml_mgmt_req_t mgmt;
	pml_pkg::pml_sw_req_t sw = '0;
	logic [1:0][4:0] rx = '0, mac = '0, tx;
	logic ack, unsup, sw_pend = 1'b0;
	logic [15:0] rdata, w, pv, m;
	logic [16:0] mx;
	logic [7:0] sw_rdata;
	pml_pkg::pml_port_ctl_t [1:0] ctl;
	logic [16:0] mq[$];
	logic [15:0] sq[$];
	int n_mismatch = 0, tests_run = 0;
	always #5 i_mclk = ~i_mclk;

	pml_mgmt_master pml_mgmt_master_i (.i_mclk(i_mclk), .o_mgmt(mgmt));
	pml_core pml_core_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_mgmt(mgmt), .o_mgmt_ack(ack),
		.o_mgmt_unsup(unsup), .o_mgmt_rdata(rdata), .i_sw(sw), .o_sw_rdata(sw_rdata),
		.i_line_rx(rx), .i_mac_tx(mac), .o_line_tx(tx), .o_port_ctl(ctl));

	////////////////////////////////////////////////////////////////////////////////
	// Answer watcher: each answer meets the oldest note
	always @(posedge i_mclk) sw_pend <= sw.req & ~sw.write;
	always @(negedge i_mclk) begin
		if (ack === 1'b1) begin
			if (mq.size() == 0) `CHK("stray ack", 1'b0, 1'b1)
			else begin
				mx = mq.pop_front();
				`CHK("mgmt answer", mx, {unsup, rdata})
			end
		end
		if (sw_pend) begin
			m = sq.pop_front();
			`CHK("switch byte", m[7:0], sw_rdata & m[15:8])
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Access, switch byte and line tasks
	task automatic mg(input logic wr, input logic [4:0] phy, input logic [4:0] ra,
		input logic [15:0] wd, input logic [16:0] ex, input logic hit);
		if (hit) mq.push_back(ex);
		pml_mgmt_master_i.access(wr, phy, ra, wd);
	endtask
	task automatic sb(input logic wr, input logic [7:0] a, wd, msk, ex);
		if (!wr) sq.push_back({msk, ex});
		@(negedge i_mclk);
		sw <= '{1'b1, wr, a, wd};
		@(negedge i_mclk);
		sw <= '{1'b0, 1'b0, ~a, ~wd};
	endtask
	task automatic ln(input logic [4:0] e0, e1);
		repeat (2) @(negedge i_mclk);
		`CHK("tx port1", e0, tx[0])
		`CHK("tx port2", e1, tx[1])
	endtask
	task automatic print_verdict();
		$display("Totals: %0d checks, %0d mismatches", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Hang guard
	initial begin
		#200000;
		n_mismatch++;
		print_verdict();
	end

	// Main sequence
	initial begin
		void'($urandom(32'h6688));
		repeat (20) @(negedge i_mclk);
		i_rst_b = 1'b1;
		rx = 10'($urandom);
		mac = 10'($urandom);
		mg(0, 5'h01, 5'h00, 0, 17'h01020, 1);
		mg(0, 5'h02, 5'h00, 0, 17'h01020, 1);
		mg(0, 5'h03, 5'h00, 0, 0, 0);
		mg(0, 5'h01, 5'h1d, 0, 17'h10000, 1);
		mg(0, 5'h02, 5'h1d, 0, 17'h00000, 1);
		mg(0, 5'h02, 5'h06, 0, 17'h10000, 1);
		mg(1, 5'h01, 5'h1e, 16'hffff, 17'h10000, 1);
		mg(0, 5'h01, 5'h0a, 0, 17'h10000, 1);
		ln(mac[0], mac[1]);
		$display("test done: reset and decode");
		mg(1, 5'h01, 5'h00, 16'hffff, 17'h01020, 1);
		mg(0, 5'h01, 5'h00, 0, 17'h0793f, 1);
		`CHK("ctl port1", 13'h1efe, ctl[0])
		ln(5'h00, rx[1]);
		pv = 16'h1020;
		for (int i = 0; i < 4; i++) begin
			w = 16'($urandom);
			mg(1, 5'h02, 5'h00, w, {1'b0, pv}, 1);
			pv = w & 16'h793f;
			mg(0, 5'h02, 5'h00, 0, {1'b0, pv}, 1);
			sb(0, 8'h2c, 0, 8'he0, {w[12], w[13], w[8], 5'h0});
			sb(0, 8'h2d, 0, 8'hff, {w[0], w[1], 1'b0, w[2], w[11], w[3], w[4], w[14]});
			sb(0, 8'h2f, 0, 8'h80, {w[5], 7'h0});
		end
		sb(1, 8'h1c, 8'h40, 0, 0);
		mg(0, 5'h01, 5'h00, 0, 17'h0683f, 1);
		$display("test done: control word and switch map");
		mg(1, 5'h01, 5'h00, 16'h2000, 17'h0683f, 1);
		mg(1, 5'h02, 5'h00, 16'h2000, {1'b0, pv}, 1);
		sb(1, 8'h1a, 8'h02, 0, 0);
		ln(rx[0], mac[1]);
		sb(1, 8'h1a, 8'h00, 0, 0);
		mg(1, 5'h02, 5'h1f, 16'h0002, 17'h00000, 1);
		ln(mac[0], rx[1]);
		sb(1, 8'h2a, 8'h00, 0, 0);
		ln(mac[0], mac[1]);
		$display("test done: loopback");
		sb(1, 8'h0f, 8'h50, 0, 0);
		sb(0, 8'h0f, 0, 8'hf8, 8'h50);
		mg(0, 5'h0a, 5'h00, 0, 17'h02000, 1);
		mg(0, 5'h0b, 5'h1d, 0, 17'h00000, 1);
		mg(0, 5'h01, 5'h00, 0, 0, 0);
		$display("test done: address relocation");
		i_rst_b = 1'b0;
		repeat (2) @(negedge i_mclk);
		i_rst_b = 1'b1;
		mg(0, 5'h01, 5'h00, 0, 17'h01020, 1);
		mg(0, 5'h0a, 5'h00, 0, 0, 0);
		for (int i = 0; i < 20 && (mq.size() + sq.size()) > 0; i++) @(negedge i_mclk);
		`CHK("answers left", 0, mq.size() + sq.size())
		$display("test done: mid-run reset");
		print_verdict();
	end
endmodule
